// >>> src/icf_monitor.sv
// One clock input: edge select, predivider and activity monitor with validation window.
// Assumes lvl is already synchronised to aclk and changes far slower than aclk.
`timescale 1ns/10ps
module icf_monitor import icf_pkg::*; #(
	parameter bit IS_XTAL = 1'b0,
	parameter int MISS_LIMIT = MISS_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic lvl,
	input wire logic edge_select,
	input wire logic monitor_feed_off,
	input wire logic [2:0] validation_window,
	input wire logic [1:0] input_prediv,
	output logic ref_pulse,
	output logic valid
);
	logic prev;
	logic [15:0] gap;
	logic [10:0] good;
	logic [2:0] div_cnt;
	wire rise = lvl & ~prev;
	wire fall = ~lvl & prev;
	wire sel_edge = edge_select ? fall : rise;
	wire mon_edge = rise & ~monitor_feed_off;
	wire missing = ~mon_edge && (gap >= 16'(MISS_LIMIT - 1));
	logic [10:0] need;
	always_comb begin
		case (validation_window)
			3'h0: need = WIN_C0;
			3'h1: need = WIN_C1;
			3'h2: need = WIN_C2;
			3'h3: need = WIN_C3;
			3'h4: need = WIN_C4;
			default: need = WIN_C5;
		endcase
	end
	// Unused crystal predivider codes fall back to divide-by-1.
	wire [2:0] dmax = IS_XTAL ? {2'h0, input_prediv == 2'h1}
		: 3'((4'h1 << input_prediv) - 4'h1);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev <= 1'b0;
			gap <= '0;
			good <= '0;
			valid <= 1'b0;
			div_cnt <= '0;
			ref_pulse <= 1'b0;
		end else begin
			prev <= lvl;
			gap <= mon_edge ? 16'h0000 : (missing ? gap : gap + 16'h0001);
			ref_pulse <= sel_edge && (div_cnt >= dmax);
			if (sel_edge)
				div_cnt <= (div_cnt >= dmax) ? 3'h0 : div_cnt + 3'h1;
			if (missing) begin
				good <= '0;
				valid <= 1'b0;
			end else if (mon_edge) begin
				if (good < need)
					good <= good + 11'h001;
				if (good + 11'h001 >= need)
					valid <= 1'b1;
			end
		end
	end

	property p_edge;
		@(posedge aclk) disable iff (!aresetn)
		ref_pulse |-> ($past(edge_select) ? $past(fall) : $past(rise));
	endproperty
	a_edge: assert property (p_edge) else $error("reference pulse on wrong edge");
	property p_feed;
		@(posedge aclk) disable iff (!aresetn)
		monitor_feed_off [*2] |=> !($rose(valid));
	endproperty
	a_feed: assert property (p_feed) else $error("valid rose with monitor fed off");
	property p_feed_n;
		@(posedge aclk) disable iff (!aresetn)
		$rose(monitor_feed_off) |-> ##[1:1000] (!valid || !monitor_feed_off);
	endproperty
	a_feed_n: assert property (p_feed_n) else $error("withheld input kept valid");
	property p_win;
		@(posedge aclk) disable iff (!aresetn)
		$rose(valid) |-> $past(mon_edge) && ($past(good) + 11'h001 >= $past(need));
	endproperty
	a_win: assert property (p_win) else $error("valid before window filled");
	property p_code;
		@(posedge aclk) disable iff (!aresetn)
		need == ((validation_window < 3'h5) ? 11'(11'h1 << (2 * validation_window)) : 11'h400);
	endproperty
	a_code: assert property (p_code) else $error("window length decode wrong");
	property p_div;
		@(posedge aclk) disable iff (!aresetn)
		ref_pulse |-> $past(div_cnt) >= $past(dmax) && $past(dmax) <= (IS_XTAL ? 3'h1 : 3'h7);
	endproperty
	a_div: assert property (p_div) else $error("predivider ratio wrong");
	property p_miss;
		@(posedge aclk) disable iff (!aresetn)
		missing |=> !valid && good == 11'h000;
	endproperty
	a_miss: assert property (p_miss) else $error("missing edge did not restart");
	c_valid: cover property (@(posedge aclk) disable iff (!aresetn) $rose(valid));
	c_lost: cover property (@(posedge aclk) disable iff (!aresetn) $fell(valid));
endmodule : icf_monitor

// >>> src/icf_pkg.sv
// Constants shared by the input clock front end: register indices, fields, timing.
// Assumes a 20 MHz aclk and registers reached over an AXI4-Lite slave.
// Operation
// - Edge select bit chooses reference edge: 0 rising, 1 falling.
// - Crystal feed-off bit set withholds the crystal signal from its monitor.
// - Numbered input feed-off bit set withholds that input from its monitor.
// - Crystal input valid only after a full edge-gap-free validation window.
// - Numbered input valid only after a full edge-gap-free validation window.
// - Window codes 0..5 give 1, 4, 16, 64, 256, 1024 cycles.
// - Crystal predivider code 00 divides by 1, code 01 by 2.
// - Numbered input predivider codes 00..11 divide by 1, 2, 4, 8.
// - First crystal pin trim, bits 3 to 0, adds to six picofarads.
// - Second crystal pin trim, bits 7 to 4, adds to six picofarads.
package icf_pkg;
	localparam logic [9:0] IDX_XTAL_CFG = 10'h300;
	localparam logic [9:0] IDX_XTAL_AMP = 10'h301;
	localparam logic [9:0] IDX_XTAL_TRIM = 10'h302;
	localparam logic [9:0] IDX_IN1_CFG = 10'h303;
	localparam logic [9:0] IDX_IN2_CFG = 10'h304;
	localparam logic [9:0] IDX_IN3_CFG = 10'h305;
	localparam logic [9:0] IDX_EVT_STATUS = 10'h306;
	localparam logic [9:0] IDX_EVT_MASK = 10'h307;
	localparam logic [9:0] IDX_LIVE = 10'h308;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam int EDGE_BIT = 6;
	localparam int FEED_BIT = 5;
	localparam int WIN_LSB = 2;
	localparam int DIV_LSB = 0;
	localparam int TRIM_A_LSB = 0;
	localparam int TRIM_B_LSB = 4;
	localparam logic [10:0] WIN_C0 = 11'h001;
	localparam logic [10:0] WIN_C1 = 11'h004;
	localparam logic [10:0] WIN_C2 = 11'h010;
	localparam logic [10:0] WIN_C3 = 11'h040;
	localparam logic [10:0] WIN_C4 = 11'h100;
	localparam logic [10:0] WIN_C5 = 11'h400;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_NS = 50;
	localparam int MISS_TIME_NS = 3200;
	localparam int MISS_CYCLES = (MISS_TIME_NS / CLK_NS < 1) ? 1 : MISS_TIME_NS / CLK_NS;
endpackage : icf_pkg

// >>> src/icf_top.sv
// Input clock front end: AXI4-Lite registers, pin synchronisers, four input monitors.
// Assumes clock inputs toggle well below half of aclk; faster inputs need a prescaler.
`timescale 1ns/10ps
module icf_top import icf_pkg::*; #(
	parameter int MISS_LIMIT = MISS_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic crystal_input,
	input wire logic [2:0] numbered_clock_input,
	output logic [3:0] synth_ref_pulse,
	output logic [3:0] input_valid,
	output logic [7:0] osc_amp_level,
	output logic [3:0] first_pin_cap_trim,
	output logic [3:0] second_pin_cap_trim,
	output logic irq
);
	// Register storage: index 0 is the crystal, 1 to 3 the numbered inputs.
	logic [7:0] in_cfg [4];
	logic [7:0] amp_reg;
	logic [7:0] trim_reg;
	logic [7:0] evt_status;
	logic [7:0] evt_mask;

	// Write channel holding registers; address and data may arrive in either order.
	logic aw_held;
	logic w_held;
	logic [9:0] aw_idx;
	logic [7:0] w_byte;
	logic w_lane0;
	logic ar_busy;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire do_write = aw_held & w_held & ~s_axi_bvalid;
	wire [9:0] ar_idx = s_axi_araddr[11:2];

	wire wr_xtal = do_write && aw_idx == IDX_XTAL_CFG;
	wire wr_amp = do_write && aw_idx == IDX_XTAL_AMP;
	wire wr_trim = do_write && aw_idx == IDX_XTAL_TRIM;
	wire wr_in1 = do_write && aw_idx == IDX_IN1_CFG;
	wire wr_in2 = do_write && aw_idx == IDX_IN2_CFG;
	wire wr_in3 = do_write && aw_idx == IDX_IN3_CFG;
	wire wr_mask = do_write && aw_idx == IDX_EVT_MASK;
	wire [3:0] wr_cfg = {wr_in3, wr_in2, wr_in1, wr_xtal};
	wire wr_hit = (aw_idx >= IDX_XTAL_CFG) && (aw_idx <= IDX_LIVE);
	wire rd_hit = (ar_idx >= IDX_XTAL_CFG) && (ar_idx <= IDX_LIVE);
	wire rd_status = ar_take && ar_idx == IDX_EVT_STATUS;

	logic [7:0] rd_val;
	always_comb begin
		case (ar_idx)
			IDX_XTAL_CFG: rd_val = in_cfg[0];
			IDX_XTAL_AMP: rd_val = amp_reg;
			IDX_XTAL_TRIM: rd_val = trim_reg;
			IDX_IN1_CFG: rd_val = in_cfg[1];
			IDX_IN2_CFG: rd_val = in_cfg[2];
			IDX_IN3_CFG: rd_val = in_cfg[3];
			IDX_EVT_STATUS: rd_val = evt_status;
			IDX_EVT_MASK: rd_val = evt_mask;
			IDX_LIVE: rd_val = {4'h0, input_valid};
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= '0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
			s_axi_wready <= ~w_held & ~w_take & ~s_axi_bvalid;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_idx <= s_axi_awaddr[11:2];
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Only byte lane 0 carries register data; other lanes are ignored.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 4; i++)
				in_cfg[i] <= REG_RST;
			amp_reg <= REG_RST;
			trim_reg <= REG_RST;
			evt_mask <= REG_RST;
		end else if (w_lane0) begin
			for (int i = 0; i < 4; i++)
				if (wr_cfg[i])
					in_cfg[i] <= w_byte & 8'h7f;
			if (wr_amp)
				amp_reg <= w_byte;
			if (wr_trim)
				trim_reg <= w_byte;
			if (wr_mask)
				evt_mask <= w_byte;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			ar_busy <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~ar_busy & ~ar_take;
			if (ar_take) begin
				ar_busy <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_val};
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				ar_busy <= 1'b0;
			end
		end
	end

	// Pin synchronisers: a new level counts once the second and third stages agree.
	logic [3:0] pin_raw;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic [3:0] pin_lvl;
	assign pin_raw = {numbered_clock_input, crystal_input};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sync3 <= 4'h0;
			pin_lvl <= 4'h0;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			for (int i = 0; i < 4; i++)
				if (sync2[i] == sync3[i])
					pin_lvl[i] <= sync3[i];
		end
	end

	logic [3:0] mon_valid;
	logic [3:0] mon_ref;
	for (genvar g = 0; g < 4; g++) begin : g_mon
		icf_monitor #(
			.IS_XTAL(g == 0),
			.MISS_LIMIT(MISS_LIMIT)
		) u_mon (
			.aclk(aclk),
			.aresetn(aresetn),
			.lvl(pin_lvl[g]),
			.edge_select(in_cfg[g][EDGE_BIT]),
			.monitor_feed_off(in_cfg[g][FEED_BIT]),
			.validation_window(in_cfg[g][WIN_LSB +: 3]),
			.input_prediv(in_cfg[g][DIV_LSB +: 2]),
			.ref_pulse(mon_ref[g]),
			.valid(mon_valid[g])
		);
	end

	// Status bits 3..0 flag a validation gained, bits 7..4 a validation lost.
	wire [7:0] evt_set = {input_valid & ~mon_valid, ~input_valid & mon_valid};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_status <= REG_RST;
			input_valid <= 4'h0;
			synth_ref_pulse <= 4'h0;
			osc_amp_level <= REG_RST;
			first_pin_cap_trim <= 4'h0;
			second_pin_cap_trim <= 4'h0;
			irq <= 1'b0;
		end else begin
			input_valid <= mon_valid;
			synth_ref_pulse <= mon_ref;
			// A new event in the cycle of the clearing read is kept.
			evt_status <= (rd_status ? 8'h00 : evt_status) | evt_set;
			irq <= |(((rd_status ? 8'h00 : evt_status) | evt_set) & evt_mask);
			osc_amp_level <= amp_reg;
			first_pin_cap_trim <= trim_reg[TRIM_A_LSB +: 4];
			second_pin_cap_trim <= trim_reg[TRIM_B_LSB +: 4];
		end
	end

	property p_trim_a;
		@(posedge aclk) disable iff (!aresetn)
		wr_trim && w_lane0 |=> ##1 first_pin_cap_trim == $past(w_byte[3:0], 2);
	endproperty
	a_trim_a: assert property (p_trim_a) else $error("first pin trim not applied");

	property p_trim_b;
		@(posedge aclk) disable iff (!aresetn)
		wr_trim && w_lane0 |=> ##1 second_pin_cap_trim == $past(w_byte[7:4], 2);
	endproperty
	a_trim_b: assert property (p_trim_b) else $error("second pin trim not applied");

	property p_edge_cfg;
		@(posedge aclk) disable iff (!aresetn)
		wr_xtal && w_lane0 |=> g_mon[0].u_mon.edge_select == $past(w_byte[EDGE_BIT]);
	endproperty
	a_edge_cfg: assert property (p_edge_cfg) else $error("edge select not stored");

	// An answer stands until the master takes it, and no new request is accepted meanwhile.
	property p_b_hold;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");

	property p_r_hold;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");

	property p_b_done;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write response repeated");

	property p_r_done;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read data repeated");

	property p_aw_shut;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_shut: assert property (p_aw_shut) else $error("write accepted during response");

	property p_ar_shut;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_shut: assert property (p_ar_shut) else $error("read accepted during response");

	property p_b_after;
		@(posedge aclk) disable iff (!aresetn)
		do_write |=> s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write not answered");

	property p_r_after;
		@(posedge aclk) disable iff (!aresetn)
		ar_take |=> s_axi_rvalid;
	endproperty
	a_r_after: assert property (p_r_after) else $error("read not answered");

	// Addresses outside the register block answer with an error and read as zero.
	property p_r_miss;
		@(posedge aclk) disable iff (!aresetn)
		ar_take && (ar_idx < IDX_XTAL_CFG || ar_idx > IDX_LIVE) |=>
			s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
	endproperty
	a_r_miss: assert property (p_r_miss) else $error("stray read not refused");

	property p_w_miss;
		@(posedge aclk) disable iff (!aresetn)
		do_write && (aw_idx < IDX_XTAL_CFG || aw_idx > IDX_LIVE) |=> s_axi_bresp == RESP_SLVERR;
	endproperty
	a_w_miss: assert property (p_w_miss) else $error("stray write not refused");

	property p_cfg_top;
		@(posedge aclk) disable iff (!aresetn)
		ar_take && ar_idx == IDX_XTAL_CFG |=> s_axi_rdata[31:7] == 25'h000_0000;
	endproperty
	a_cfg_top: assert property (p_cfg_top) else $error("reserved config bit reads set");

	property p_live;
		@(posedge aclk) disable iff (!aresetn)
		ar_take && ar_idx == IDX_LIVE |=> s_axi_rdata == {28'h000_0000, $past(input_valid)};
	endproperty
	a_live: assert property (p_live) else $error("live valid bits misread");

	// Status bits stay set until a clearing read, and a new event always wins over the clear.
	property p_sticky;
		@(posedge aclk) disable iff (!aresetn)
		!rd_status |=> (evt_status & $past(evt_status)) == $past(evt_status);
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit lost without a read");

	property p_set_wins;
		@(posedge aclk) disable iff (!aresetn)
		|evt_set |=> (evt_status & $past(evt_set)) == $past(evt_set);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("status event not recorded");

	property p_clear;
		@(posedge aclk) disable iff (!aresetn)
		rd_status && evt_set == 8'h00 |=> evt_status == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("status read did not clear");

	property p_irq;
		@(posedge aclk) disable iff (!aresetn)
		irq == |(evt_status & $past(evt_mask));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level disagrees with status");

	property p_sync;
		@(posedge aclk) disable iff (!aresetn)
		((pin_lvl ^ $past(pin_lvl)) & ($past(sync2) ^ $past(sync3))) == 4'h0;
	endproperty
	a_sync: assert property (p_sync) else $error("pin level moved before stages agreed");

	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
	c_write: cover property (@(posedge aclk) disable iff (!aresetn) do_write ##1 s_axi_bvalid);
	c_read: cover property (@(posedge aclk) disable iff (!aresetn) ar_take ##1 s_axi_rvalid);
endmodule : icf_top

// >>> tb/icf_clk_src.sv
// Far-side model: four reference clock sources sharing one period.
// Assumes the bench aclk; every line holds its level while run is low.
`timescale 1ns/10ps
module icf_clk_src #(
	parameter int HALF = 4
) (
	input wire logic aclk,
	input wire logic run,
	output logic xtal,
	output logic [2:0] clk_in
);
	int cnt = 0;
	initial xtal = 1'b0;
	initial clk_in = 3'h0;
	// Stopping the sources is how missing edges are produced.
	always @(posedge aclk) begin
		if (run) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) begin
				xtal <= ~xtal;
				clk_in <= ~clk_in;
			end
		end
	end
endmodule : icf_clk_src

// >>> tb/tb_top.sv
// Bench for the input clock front end: AXI4-Lite register tasks and monitor scenarios.
// Assumes a clock source period of 8 aclk cycles, well inside the miss limit of 16.
`timescale 1ns/10ps
module tb_top import icf_pkg::*; ;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic run = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, xtal, prev = 1'b0;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] clk_in;
	logic [3:0] pulse, valid, trim_a, trim_b;
	logic [7:0] amp;
	int err_total = 0, num_checks = 0, since = 0, ph = 0, ph0;
	int pc[4] = '{0, 0, 0, 0};
	int sn[4];
	int pexp[4] = '{50, 50, 25, 12};
	initial forever #25 aclk = ~aclk;
	icf_clk_src #(.HALF(4)) u_icf_clk_src (.aclk(aclk), .run(run), .xtal(xtal), .clk_in(clk_in));
	icf_top #(.MISS_LIMIT(16)) u_icf_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.crystal_input(xtal), .numbered_clock_input(clk_in), .synth_ref_pulse(pulse),
		.input_valid(valid), .osc_amp_level(amp), .first_pin_cap_trim(trim_a),
		.second_pin_cap_trim(trim_b), .irq(irq));
	// Phase of the input 1 reference pulse against the last rising edge of its source.
	always @(posedge aclk) begin
		since <= (clk_in[0] && !prev) ? 0 : since + 1;
		prev <= clk_in[0];
		if (pulse[1]) ph <= since;
		for (int i = 0; i < 4; i++) if (pulse[i]) pc[i] <= pc[i] + 1;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er);
	endtask : wr
	task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, exp);
		chk(rresp, er);
	endtask : rd
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd(IDX_XTAL_CFG + 10'(i), 32'h0, RESP_OKAY);
		for (int i = 3; i < 6; i++) wr(IDX_XTAL_CFG + 10'(i), 8'hff, RESP_OKAY);
		for (int i = 3; i < 6; i++) rd(IDX_XTAL_CFG + 10'(i), 32'h7f, RESP_OKAY);
		wr(IDX_XTAL_AMP, 8'h50, RESP_OKAY);
		wr(IDX_XTAL_TRIM, 8'ha5, RESP_OKAY);
		rd(IDX_XTAL_TRIM, 32'ha5, RESP_OKAY);
		chk(amp, 8'h50);
		chk(trim_a, 4'h5);
		chk(trim_b, 4'ha);
		rd(10'h309, 32'h0, RESP_SLVERR);
		wr(10'h0ff, 8'h12, RESP_SLVERR);
		// Crystal divide-by-2 is safe here: the frequency doubler is not part of this block.
		wr(IDX_XTAL_CFG, 8'h01, RESP_OKAY);
		wr(IDX_IN1_CFG, 8'h05, RESP_OKAY);
		wr(IDX_IN2_CFG, 8'h0a, RESP_OKAY);
		wr(IDX_IN3_CFG, 8'h0f, RESP_OKAY);
		wr(IDX_EVT_MASK, 8'h0f, RESP_OKAY);
		rd(IDX_EVT_STATUS, 32'h0, RESP_OKAY);
		run <= 1'b1;
		repeat (80) @(posedge aclk);
		chk(valid, 4'b0011);
		repeat (220) @(posedge aclk);
		chk(valid, 4'b0111);
		repeat (400) @(posedge aclk);
		chk(valid, 4'b1111);
		chk(irq, 1'b1);
		sn = pc;
		repeat (800) @(posedge aclk);
		for (int i = 0; i < 4; i++)
			chk(32'((pc[i] - sn[i] - pexp[i]) ** 2 <= 1), 32'h1);
		rd(IDX_EVT_STATUS, 32'h0f, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		wr(IDX_IN1_CFG, 8'h04, RESP_OKAY);
		repeat (50) @(posedge aclk);
		ph0 = ph;
		wr(IDX_IN1_CFG, 8'h44, RESP_OKAY);
		repeat (50) @(posedge aclk);
		chk((ph - ph0 + 8) % 8, 32'h4);
		wr(IDX_EVT_MASK, 8'hf0, RESP_OKAY);
		wr(IDX_XTAL_CFG, 8'h21, RESP_OKAY);
		repeat (40) @(posedge aclk);
		chk(valid, 4'b1110);
		chk(irq, 1'b1);
		wr(IDX_EVT_MASK, 8'h00, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		wr(IDX_IN3_CFG, 8'h2f, RESP_OKAY);
		repeat (40) @(posedge aclk);
		chk(valid, 4'b0110);
		run <= 1'b0;
		repeat (40) @(posedge aclk);
		chk(valid, 4'b0000);
		rd(IDX_EVT_STATUS, 32'hf0, RESP_OKAY);
		run <= 1'b1;
		repeat (300) @(posedge aclk);
		chk(valid, 4'b0110);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		conclude();
	end
endmodule : tb_top
